// File: src/priority_interrupt_sequencer.sv
// Purpose: sixteen-level priority interrupt and instruction sequencing control
// Assumes: core and memory share pclk; ext_flag_set comes from outside pins
// Notes: pointer and index words live in external memory; mem_cmd reaches only the pointer words
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps

// Summary of operation
// RULE1: fifteen request flip-flops, one per upper level
// RULE2: lowest level always requests when others idle
// RULE3: flags set by instruction or external pins
// RULE4: flag clears only by drop at own level
// RULE5: flags examined during every instruction
// RULE6: switch only after current instruction completes
// RULE7: higher levels preempt; interrupted level resumes later
// RULE8: switch saves interrupted level's next address
// RULE9: sixteen pointer words, one per level
// RULE10: pointer decrements unless branch given
// RULE11: top 128 words form sixteen eight-word sections
// RULE12: six index registers per level section
// RULE13: addresses wrap modulo installed memory size
// RULE14: two odd parity bits per word
// RULE15: parity error traps, or halts when off-line
// RULE16: one 30-bit result holding register
// RULE17: result holding register not saved on switch
// RULE18: arithmetic overflow sets excess indicator
// RULE19: fetch address is pointer bits 16-29
// RULE20: overflow sets pointer bit 0 of level
// RULE21: lower flags never interrupt higher level
// RULE22: lower flag index means higher priority
// RULE23: executive words use ordinary memory port
module priority_interrupt_sequencer import sequencer_pkg::*; #(
	parameter logic [13:0] SUPERVISOR_ADDR = SUPERVISOR_RESET
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [14:0] ext_flag_set,
	input wire instr_result_t instr,
	output logic [29:0] result_holding_register,
	output logic [13:0] next_fetch_pointer,
	output logic fetch_valid,
	output logic [3:0] active_level,
	output logic [13:0] index_base,
	output logic parity_trap,
	output logic parity_error,
	output logic halted,
	output logic overflow,
	output mem_cmd_t mem_cmd,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);

	// ------------------------------------------------------------
	// state layout
	// ------------------------------------------------------------
	typedef struct packed {
		seq_state_t fsm;
		logic [14:0] flags;
		logic [3:0] level;
		logic [13:0] fetch;
		logic fetch_valid;
		logic [29:0] acc;
		logic [14:0] sync1;
		logic [14:0] sync2;
		logic run;
		logic offline;
		logic [1:0] size;
		logic halted;
		logic perr;
		logic ovf;
		logic parity_trap;
		logic branch;
		logic [13:0] target;
		logic instr_ovf;
		logic [13:0] index_base;
		mem_cmd_t mem;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_t;

	// ------------------------------------------------------------
	// address and parity helpers
	// ------------------------------------------------------------
	function automatic logic [13:0] size_mask(input logic [1:0] sel);
		logic [13:0] m;
		m = MASK_16K;
		if (sel == SIZE_4K) begin
			m = MASK_4K;
		end else if (sel == SIZE_8K) begin
			m = MASK_8K;
		end
		return m;
	endfunction

	// executive space sits in the top 128 words of whatever is installed
	function automatic logic [13:0] section_addr(input logic [1:0] sel, input logic [3:0] lvl,
		input logic [2:0] off);
		return (size_mask(sel) & ~EXEC_MASK) | {7'h00, lvl, off}; // [RULE11] [RULE13]
	endfunction

	function automatic logic [31:0] with_parity(input logic [29:0] w);
		return {~^w[29:HALF_SPLIT], ~^w[HALF_SPLIT-1:0], w}; // [RULE14]
	endfunction

	function automatic logic parity_ok(input logic [31:0] w);
		return (^{w[31], w[29:HALF_SPLIT]}) & (^{w[30], w[HALF_SPLIT-1:0]}); // [RULE14]
	endfunction

	// lowest index wins; the lowest level answers when nothing is set
	function automatic logic [3:0] highest_demand(input logic [14:0] f);
		logic [3:0] l;
		l = LOWEST_LEVEL; // [RULE2]
		for (int i = FLAG_COUNT - 1; i >= 0; i--) begin
			if (f[i]) begin
				l = 4'(i); // [RULE22]
			end
		end
		return l;
	endfunction

	// ------------------------------------------------------------
	// pointer and fault helpers
	// ------------------------------------------------------------
	// next pointer word: target or one below, wrapped; overflow sticks, fill bits set
	function automatic logic [29:0] next_pointer(input logic [29:0] old, input logic br,
		input logic [13:0] tgt, input logic ovf, input logic [13:0] m);
		logic [13:0] a;
		a = br ? (tgt & m) : ((old[PTR_ADDR_HI:0] - 14'h0001) & m); // [RULE10] [RULE13]
		return {ovf | old[PTR_OVF_BIT], 15'h7fff, a}; // [RULE20]
	endfunction

	// on-line a bad word traps to the supervisor; off-line the sequencer stops
	function automatic state_t parity_fault(input state_t s, input logic off);
		state_t t;
		t = s;
		t.mem.req = 1'b0;
		t.perr = 1'b1; // [RULE15]
		t.halted = s.halted | off;
		t.parity_trap = !off;
		t.fetch = SUPERVISOR_ADDR;
		t.fetch_valid = !off;
		t.fsm = off ? ST_HALT : ST_IDLE;
		return t;
	endfunction

	// ------------------------------------------------------------
	// register read decode
	// ------------------------------------------------------------
	// registered read answer; unmapped offsets only raise the error flag
	function automatic logic [32:0] read_word(input logic [7:0] a, input state_t s);
		logic [31:0] d;
		logic miss;
		d = 32'h0000_0000;
		miss = 1'b0;
		case (a)
			CTRL_OFFSET: begin
				d[CTRL_RUN_BIT] = s.run;
				d[CTRL_OFFLINE_BIT] = s.offline;
				d[CTRL_SIZE_LO+1:CTRL_SIZE_LO] = s.size;
			end
			STATUS_OFFSET: begin
				d[LEVEL_W-1:0] = s.level;
				d[ST_HALT_BIT] = s.halted;
				d[ST_PERR_BIT] = s.perr;
				d[ST_OVF_BIT] = s.ovf;
				d[ST_FETCH_VALID_BIT] = s.fetch_valid;
			end
			FLAGS_OFFSET: d[FLAG_COUNT-1:0] = s.flags;
			ACC_OFFSET: d[WORD_W-1:0] = s.acc;
			FETCH_OFFSET: d[ADDR_W-1:0] = s.fetch;
			default: miss = 1'b1;
		endcase
		return {miss, d};
	endfunction

	// ------------------------------------------------------------
	// state and working signals
	// ------------------------------------------------------------
	state_t r;
	state_t n;
	logic [14:0] set_mask;
	logic [14:0] clr_mask;
	logic apb_access;
	logic apb_write;
	logic [13:0] mask;
	logic [29:0] new_ptr;
	logic [3:0] pick;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		n.parity_trap = 1'b0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		// two stages before any flag logic sees the pins
		n.sync1 = ext_flag_set;
		n.sync2 = r.sync1;
		set_mask = r.sync2; // [RULE3]
		clr_mask = 15'h0000;
		mask = size_mask(r.size);
		// prepared from the word on the bus; used only in the pointer-read state
		new_ptr = next_pointer(mem_rdata[WORD_W-1:0], r.branch, r.target, r.instr_ovf,
			mask); // [RULE10] [RULE20]
		pick = highest_demand(r.flags); // [RULE21]
		apb_access = psel & penable;
		apb_write = apb_access & r.pready & pwrite;

		// ------------------------------------------------------------
		// bus answer
		// ------------------------------------------------------------
		// one wait state: data is registered in the same cycle that pready rises
		if (apb_access && !r.pready) begin
			n.pready = 1'b1;
			{n.pslverr, n.prdata} = read_word(paddr, r);
		end

		// ------------------------------------------------------------
		// software writes
		// ------------------------------------------------------------
		// software writes go first so that hardware sets below win
		if (apb_write) begin
			case (paddr)
				CTRL_OFFSET: begin
					n.run = pwdata[CTRL_RUN_BIT];
					n.offline = pwdata[CTRL_OFFLINE_BIT];
					n.size = pwdata[CTRL_SIZE_LO+1:CTRL_SIZE_LO];
				end
				STATUS_OFFSET: begin
					if (pwdata[ST_HALT_BIT]) begin
						n.halted = 1'b0;
					end
					if (pwdata[ST_PERR_BIT]) begin
						n.perr = 1'b0;
					end
					if (pwdata[ST_OVF_BIT]) begin
						n.ovf = 1'b0;
					end
				end
				FLAGS_OFFSET: set_mask = set_mask | pwdata[FLAG_COUNT-1:0]; // [RULE3]
				ACC_OFFSET: n.acc = pwdata[WORD_W-1:0]; // [RULE16]
				default: begin
				end
			endcase
		end

		// ------------------------------------------------------------
		// instruction sequencing
		// ------------------------------------------------------------
		case (r.fsm)
			ST_IDLE: begin
				// flags keep moving while the instruction runs
				// a strobe while no fetch is valid belongs to no instruction
				if (instr.done && r.fetch_valid) begin
					n.fetch_valid = 1'b0;
					n.branch = instr.branch;
					n.target = instr.target;
					n.instr_ovf = instr.overflow;
					set_mask = set_mask | instr.flag_set; // [RULE3] [RULE5]
					if (instr.drop && r.level != LOWEST_LEVEL) begin
						clr_mask[r.level] = 1'b1; // [RULE4]
					end
					if (instr.acc_we) begin
						n.acc = instr.acc_data; // [RULE16]
					end
					if (instr.overflow) begin
						n.ovf = 1'b1; // [RULE18]
					end
					n.mem.req = 1'b1;
					n.mem.we = 1'b0;
					n.mem.addr = section_addr(r.size, r.level, PTR_OFFSET); // [RULE9] [RULE23]
					n.fsm = ST_RD_PTR;
				end
			end
			ST_RD_PTR: begin
				if (mem_ack) begin
					n.mem.req = 1'b0;
					if (!parity_ok(mem_rdata)) begin
						// no write-back: a bad pointer must not be made to look good
						n = parity_fault(n, r.offline); // [RULE14] [RULE15]
					end else begin
						// save happens before any level change is decided
						n.mem.req = 1'b1;
						n.mem.we = 1'b1;
						n.mem.wdata = with_parity(new_ptr); // [RULE8] [RULE14]
						n.fsm = ST_WR_PTR;
					end
				end
			end
			ST_WR_PTR: begin
				if (mem_ack) begin
					n.mem.req = 1'b0;
					n.fsm = ST_SELECT;
				end
			end
			ST_SELECT: begin
				// accumulator deliberately left alone across the switch
				if (r.run) begin
					n.level = pick; // [RULE6] [RULE7] [RULE17]
					n.index_base = section_addr(r.size, pick, INDEX_FIRST); // [RULE12]
					n.mem.req = 1'b1;
					n.mem.we = 1'b0;
					n.mem.addr = section_addr(r.size, pick, PTR_OFFSET); // [RULE23]
					n.fsm = ST_RD_NEW;
				end
			end
			ST_RD_NEW: begin
				if (mem_ack) begin
					if (!parity_ok(mem_rdata)) begin
						n = parity_fault(n, r.offline); // [RULE14] [RULE15]
					end else begin
						n.mem.req = 1'b0;
						n.fsm = ST_IDLE;
						n.fetch_valid = 1'b1;
						n.fetch = mem_rdata[PTR_ADDR_HI:0] & mask; // [RULE19] [RULE13]
					end
				end
			end
			ST_HALT: begin
				if (!r.halted) begin
					n.fsm = ST_SELECT;
				end
			end
			default: n.fsm = ST_SELECT;
		endcase

		// ------------------------------------------------------------
		// flag register
		// ------------------------------------------------------------
		// set wins over the drop in the same cycle, so no request is lost
		n.flags = (r.flags & ~clr_mask) | set_mask; // [RULE1]
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.fsm <= ST_SELECT;
			r.size <= SIZE_RESET;
		end else begin
			r <= n;
		end
	end

	// ------------------------------------------------------------
	// outputs, all straight from the state register
	// ------------------------------------------------------------
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign result_holding_register = r.acc;
	assign next_fetch_pointer = r.fetch;
	assign fetch_valid = r.fetch_valid;
	assign active_level = r.level;
	assign index_base = r.index_base;
	assign parity_trap = r.parity_trap;
	assign parity_error = r.perr;
	assign halted = r.halted;
	assign overflow = r.ovf;
	assign mem_cmd = r.mem;

endmodule

// File: src/sequencer_pkg.sv
// Purpose: shared constants and types of the priority interrupt sequencer
// Assumes: 30-bit data words; memory words carry two parity bits on top
// Notes: documented bit 0 is the word's msb, documented bit 29 its lsb
package sequencer_pkg;

	// ------------------------------------------------------------
	// word and level geometry
	// ------------------------------------------------------------
	localparam int WORD_W = 30;
	localparam int MEM_W = 32;
	localparam int ADDR_W = 14;
	localparam int FLAG_COUNT = 15;
	localparam int LEVEL_W = 4;
	localparam logic [3:0] LOWEST_LEVEL = 4'hf;
	localparam int EXEC_WORDS = 128;
	localparam int SECTION_WORDS = 8;
	localparam int INDEX_COUNT = 6;
	localparam logic [2:0] PTR_OFFSET = 3'h0;
	localparam logic [2:0] INDEX_FIRST = 3'h1;

	// ------------------------------------------------------------
	// pointer word fields (lsb numbering)
	// ------------------------------------------------------------
	localparam int PTR_OVF_BIT = 29;
	localparam int PTR_FILL_HI = 28;
	localparam int PTR_FILL_LO = 14;
	localparam int PTR_ADDR_HI = 13;
	localparam int HALF_SPLIT = 15;

	// ------------------------------------------------------------
	// installed memory size codes and address masks
	// ------------------------------------------------------------
	localparam logic [1:0] SIZE_4K = 2'h0;
	localparam logic [1:0] SIZE_8K = 2'h1;
	localparam logic [13:0] MASK_4K = 14'h0fff;
	localparam logic [13:0] MASK_8K = 14'h1fff;
	localparam logic [13:0] MASK_16K = 14'h3fff;
	localparam logic [13:0] EXEC_MASK = 14'h007f;

	// ------------------------------------------------------------
	// register map, byte addresses, reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] FLAGS_OFFSET = 8'h08;
	localparam logic [7:0] ACC_OFFSET = 8'h0c;
	localparam logic [7:0] FETCH_OFFSET = 8'h10;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_OFFLINE_BIT = 1;
	localparam int CTRL_SIZE_LO = 2;
	localparam int ST_HALT_BIT = 4;
	localparam int ST_PERR_BIT = 5;
	localparam int ST_OVF_BIT = 6;
	localparam int ST_FETCH_VALID_BIT = 7;
	localparam logic [1:0] SIZE_RESET = SIZE_4K;
	localparam logic [13:0] SUPERVISOR_RESET = 14'h0000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RD_PTR = 3'b001,
		ST_WR_PTR = 3'b011,
		ST_SELECT = 3'b010,
		ST_RD_NEW = 3'b110,
		ST_HALT = 3'b100
	} seq_state_t;

	typedef struct packed {
		logic done;
		logic drop;
		logic branch;
		logic [13:0] target;
		logic overflow;
		logic acc_we;
		logic [29:0] acc_data;
		logic [14:0] flag_set;
	} instr_result_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [13:0] addr;
		logic [31:0] wdata;
	} mem_cmd_t;

endpackage

// File: testbench/seq_checker_sva.sv
// Purpose: port-level checks of the priority interrupt sequencer
// Assumes: sees only top ports, one clock domain
// Notes: bound from the bench top file
`timescale 1ns/10ps
module seq_checker import sequencer_pkg::*; #(
	parameter logic [13:0] SUPERVISOR_ADDR = 14'h0000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire instr_result_t instr,
	input wire logic fetch_valid,
	input wire logic [3:0] active_level,
	input wire logic [13:0] next_fetch_pointer,
	input wire logic parity_trap,
	input wire mem_cmd_t mem_cmd,
	input wire logic mem_ack
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----
	// checks
	// ----
	AST_APB_ONE: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer not a single cycle after one wait");
	AST_SWITCH_AFTER_DONE: assert property (instr.done && fetch_valid |=> !fetch_valid)
		else $error("fetch still valid after instruction end");
	AST_LEVEL_HELD: assert property (fetch_valid && !instr.done |=> $stable(active_level))
		else $error("level changed inside an instruction");
	AST_REQ_HELD: assert property (mem_cmd.req && !mem_ack |=> mem_cmd.req && $stable(mem_cmd))
		else $error("memory request moved before ack");
	AST_PTR_SLOT: assert property (mem_cmd.req |-> mem_cmd.addr[2:0] == PTR_OFFSET && &mem_cmd.addr[11:7])
		else $error("memory access outside pointer slots");
	AST_PTR_LEVEL: assert property (mem_cmd.req |-> mem_cmd.addr[6:3] == active_level)
		else $error("pointer slot not of active level");
	AST_PTR_ONES: assert property (mem_cmd.req && mem_cmd.we |-> mem_cmd.wdata[28:14] == 15'h7fff)
		else $error("saved pointer fill bits not ones");
	AST_PARITY_GEN: assert property (mem_cmd.req && mem_cmd.we |->
		mem_cmd.wdata[31] == ~^mem_cmd.wdata[29:15] && mem_cmd.wdata[30] == ~^mem_cmd.wdata[14:0])
		else $error("written parity not odd");
	AST_TRAP: assert property (parity_trap |-> ##[0:1] (fetch_valid && next_fetch_pointer == SUPERVISOR_ADDR))
		else $error("trap did not redirect fetch");
	AST_REFILL: assert property ($rose(fetch_valid) |-> $past(mem_ack))
		else $error("fetch valid without pointer read");
	cover property (parity_trap);
	cover property (instr.done && fetch_valid);
	cover property (mem_cmd.req && mem_cmd.we && mem_ack);
endmodule

// File: testbench/mem_model.sv
// Purpose: memory partner holding pointer words with parity
// Assumes: full 14-bit array, wrapping is the design's job
// Notes: lat sets idle cycles before ack; change only between requests
`timescale 1ns/10ps
module mem_model import sequencer_pkg::*; (
	input wire logic pclk,
	input wire mem_cmd_t mem_cmd,
	input wire logic [1:0] lat,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic [31:0] mem [0:16383];
	logic [1:0] wait_cnt = 2'h0;
	logic [31:0] junk = 32'h0;
	assign mem_ack = mem_cmd.req && wait_cnt == lat;
	// stale data toggles so a late sample can never look right
	assign mem_rdata = (mem_ack && !mem_cmd.we) ? mem[mem_cmd.addr] : junk;
	always @(posedge pclk) begin
		junk <= ~junk ^ 32'h1;
		if (mem_ack) begin
			wait_cnt <= 2'h0;
			if (mem_cmd.we)
				mem[mem_cmd.addr] <= mem_cmd.wdata;
		end else if (mem_cmd.req)
			wait_cnt <= wait_cnt + 2'h1;
	end
endmodule

// File: testbench/test_priority_interrupt_sequencer.sv
// Purpose: directed bench for the priority interrupt sequencer
// Assumes: apb master here, memory partner in mem_model
// Notes: expected pointers worked out here, never read from the design
`timescale 1ns/10ps
module test_priority_interrupt_sequencer;
	import sequencer_pkg::*;
	localparam logic [13:0] SUP = 14'h0123;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, mem_rdata, q;
	logic pready, pslverr, fetch_valid, parity_trap, parity_error, halted, overflow, mem_ack, e;
	logic [14:0] ext_flag_set = 15'h0;
	instr_result_t instr = '0;
	logic [29:0] result_holding_register;
	logic [13:0] next_fetch_pointer, index_base;
	logic [3:0] active_level;
	mem_cmd_t mem_cmd;
	logic [1:0] lat = 2'h0;
	int err_total = 0;
	int check_count = 0;
	int cycles = 0;
	always #10 pclk = ~pclk;
	priority_interrupt_sequencer #(.SUPERVISOR_ADDR(SUP)) dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ext_flag_set(ext_flag_set),
		.instr(instr),
		.result_holding_register(result_holding_register),
		.next_fetch_pointer(next_fetch_pointer),
		.fetch_valid(fetch_valid),
		.active_level(active_level),
		.index_base(index_base),
		.parity_trap(parity_trap),
		.parity_error(parity_error),
		.halted(halted),
		.overflow(overflow),
		.mem_cmd(mem_cmd),
		.mem_ack(mem_ack),
		.mem_rdata(mem_rdata)
	);
	mem_model mem_i (
		.pclk(pclk),
		.mem_cmd(mem_cmd),
		.lat(lat),
		.mem_ack(mem_ack),
		.mem_rdata(mem_rdata)
	);
	// ----
	// helpers
	// ----
	function automatic logic [31:0] pw(input logic [29:0] d);
		return {~^d[29:15], ~^d[14:0], d};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
		chk(32'(e), 32'h0);
	endtask
	task automatic wait_fv();
		@(negedge pclk);
		while (fetch_valid !== 1'b1) @(negedge pclk);
	endtask
	// acc_data mirrors flags and target so every step also loads the accumulator
	task automatic go(input logic dr, input logic br, input logic [13:0] t, input logic ov,
		input logic [14:0] fs);
		@(posedge pclk);
		instr <= {1'b1, dr, br, t, ov, 1'b1, fs, 1'b0, t, fs};
		@(posedge pclk);
		instr <= '0;
		wait_fv();
	endtask
	task automatic at(input logic [3:0] l, input logic [13:0] f);
		chk(32'(active_level), 32'(l));
		chk(32'(next_fetch_pointer), 32'(f));
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			conclude();
		end
	end
	// ----
	// sequence
	// ----
	initial begin
		for (int i = 0; i < 16; i++)
			mem_i.mem[14'h0f80 | 14'(i * 8)] = pw({16'h0, 2'b00, 4'(i), 8'h20});
		mem_i.mem[14'h1ff8] = pw(30'h0000_1234);
		mem_i.mem[14'h3ff8] = pw(30'h0000_0100);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(CTRL_OFFSET, 32'h0);
		rd(STATUS_OFFSET, 32'h0);
		rd(FLAGS_OFFSET, 32'h0);
		apb(1'b1, 8'h14, 32'h1);
		chk(32'(e), 32'h1);
		apb(1'b1, CTRL_OFFSET, 32'h1);
		wait_fv();
		at(4'hf, 14'h0f20);
		go(1'b0, 1'b0, 14'h0, 1'b0, 15'h0);
		at(4'hf, 14'h0f1f);
		go(1'b0, 1'b0, 14'h0, 1'b1, 15'h0020);
		at(4'h5, 14'h0520);
		chk(32'(overflow), 32'h1);
		chk(32'(result_holding_register), 32'h0010_0000);
		chk(mem_i.mem[14'h0ff8], pw({1'b1, 15'h7fff, 14'h0f1e}));
		chk(32'(index_base), 32'h0fa9);
		@(posedge pclk);
		ext_flag_set <= 15'h0200;
		repeat (4) @(posedge pclk);
		ext_flag_set <= 15'h0;
		rd(FLAGS_OFFSET, 32'h0220);
		go(1'b0, 1'b1, 14'h0abc, 1'b0, 15'h0);
		at(4'h5, 14'h0abc);
		apb(1'b1, FLAGS_OFFSET, 32'h4);
		go(1'b0, 1'b0, 14'h0, 1'b0, 15'h0);
		at(4'h2, 14'h0220);
		chk(mem_i.mem[14'h0fa8], pw({1'b0, 15'h7fff, 14'h0abb}));
		go(1'b1, 1'b0, 14'h0, 1'b0, 15'h0);
		at(4'h5, 14'h0abb);
		lat <= 2'h2;
		go(1'b1, 1'b0, 14'h0, 1'b0, 15'h0);
		at(4'h9, 14'h0920);
		go(1'b1, 1'b0, 14'h0, 1'b0, 15'h0);
		at(4'hf, 14'h0f1e);
		rd(FLAGS_OFFSET, 32'h0);
		rd(STATUS_OFFSET, 32'h0cf);
		apb(1'b1, STATUS_OFFSET, 32'h40);
		apb(1'b1, ACC_OFFSET, 32'h1555_aaaa);
		rd(ACC_OFFSET, 32'h1555_aaaa);
		apb(1'b1, CTRL_OFFSET, 32'h5);
		go(1'b0, 1'b1, 14'h3abc, 1'b0, 15'h0);
		at(4'hf, 14'h1abc);
		chk(mem_i.mem[14'h1ff8], pw({1'b0, 15'h7fff, 14'h1abc}));
		rd(ACC_OFFSET, 32'h3abc);
		chk(32'(result_holding_register), 32'h3abc);
		mem_i.mem[14'h1ff8] ^= 32'h1;
		go(1'b0, 1'b0, 14'h0, 1'b0, 15'h0);
		at(4'hf, SUP);
		chk(32'(parity_error), 32'h1);
		rd(STATUS_OFFSET, 32'h0af);
		apb(1'b1, CTRL_OFFSET, 32'h7);
		@(posedge pclk);
		instr <= 64'h8000_0000_0000_0000;
		@(posedge pclk);
		instr <= '0;
		while (halted !== 1'b1) @(negedge pclk);
		rd(STATUS_OFFSET, 32'h03f);
		mem_i.mem[14'h1ff8] ^= 32'h1;
		apb(1'b1, STATUS_OFFSET, 32'h30);
		wait_fv();
		at(4'hf, 14'h1abc);
		rd(STATUS_OFFSET, 32'h08f);
		chk(32'(halted), 32'h0);
		rd(FETCH_OFFSET, 32'h1abc);
		rd(CTRL_OFFSET, 32'h7);
		apb(1'b1, CTRL_OFFSET, 32'h9);
		go(1'b0, 1'b1, 14'h3abc, 1'b0, 15'h0);
		at(4'hf, 14'h3abc);
		chk(mem_i.mem[14'h3ff8], pw({1'b0, 15'h7fff, 14'h3abc}));
		conclude();
	end
endmodule
bind priority_interrupt_sequencer seq_checker #(.SUPERVISOR_ADDR(SUPERVISOR_ADDR)) chk_i (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.instr(instr),
	.fetch_valid(fetch_valid),
	.active_level(active_level),
	.next_fetch_pointer(next_fetch_pointer),
	.parity_trap(parity_trap),
	.mem_cmd(mem_cmd),
	.mem_ack(mem_ack)
);
